// file: bench/memory_region_sram_config_test.sv
// Self-checking bench for the memory region block
`timescale 1ns/1ps
module memory_region_sram_config_test;
    import mrsc_pkg::*;
    logic        clk, srst, isram_en, cache_en, parity_en;
    logic        ret_isram, ret_dsram, hib_wake, core_excl;
    logic        core_req, core_we, dma_req, dma_we, core_ack, core_err;
    logic        core_excl_ok, dma_ack, dma_err, code_sel, mmr_sel;
    logic        sys_sel, parity_err, cache_inval, ok, bad;
    logic [31:0] core_addr, core_wdata, dma_addr, dma_wdata, q;
    logic [31:0] core_rdata, dma_rdata, fwd_addr;
    logic [1:0]  core_size, dma_size;
    logic [5:0]  ret_kb;
    logic [6:0]  dsram_kb;
    int          fails, n_checks, cyc, n;
    logic [31:0] pa[5] = '{32'h0, 32'h0003_fffc, 32'h2004_0000,
                           32'he000_0000, 32'hf7ff_fffc};
    logic [2:0]  ps[5] = '{3'h4, 3'h4, 3'h2, 3'h1, 3'h1};

    mrsc_master core_m (.clk, .req(core_req), .we(core_we),
        .addr(core_addr), .size(core_size), .wdata(core_wdata),
        .excl(core_excl), .ack(core_ack), .err(core_err),
        .rdata(core_rdata));
    mrsc_master dma_m (.clk, .req(dma_req), .we(dma_we),
        .addr(dma_addr), .size(dma_size), .wdata(dma_wdata), .excl(),
        .ack(dma_ack), .err(dma_err), .rdata(dma_rdata));
    mrsc_region dut (.clk, .srst, .core_req, .core_we, .core_addr,
        .core_size, .core_wdata, .core_excl, .dma_req, .dma_we, .dma_addr,
        .dma_size, .dma_wdata, .isram_en, .cache_en, .parity_en,
        .ret_isram, .ret_dsram, .hib_wake, .core_ack, .core_err,
        .core_rdata, .core_excl_ok, .dma_ack, .dma_err, .dma_rdata,
        .code_sel, .mmr_sel, .sys_sel, .fwd_addr, .parity_err,
        .cache_inval, .ret_kb, .dsram_kb);

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Value compare, and flag compare on top of it
    task automatic chk32(input logic [31:0] g, e, input string m);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
        end
    endtask : chk32
    task automatic chk1(input logic g, e, input string m);
        chk32({31'h0, g}, {31'h0, e}, m);
    endtask : chk1

    // Core access: only one cycle allowed for the answer
    task automatic core_ok(input logic w, input logic [31:0] a,
                           input logic [1:0] s, input logic [31:0] d, e);
        logic o, b;
        logic [31:0] r;
        int c;
        core_m.xfer(w, a, s, d, 1'b0, 1, o, b, r, c);
        chk1(o, 1'b1, "core ack");
        if (!w) chk32(r, e, "core rdata");
    endtask : core_ok
    // DMA access, may be held off by the core; cycles come back in c
    task automatic dma_ok(input logic w, input logic [31:0] a,
                          input logic [31:0] d, e, output int c);
        logic o, b;
        logic [31:0] r;
        dma_m.xfer(w, a, 2'h2, d, 1'b0, 4, o, b, r, c);
        chk1(o, 1'b1, "dma ack");
        if (!w) chk32(r, e, "dma rdata");
    endtask : dma_ok
    // Single-cycle read whose side flags the caller inspects
    task automatic probe(input logic dm, input logic [31:0] a,
                         input logic [1:0] s);
        if (dm) dma_m.xfer(1'b0, a, s, 32'h0, 1'b0, 1, ok, bad, q, cyc);
        else core_m.xfer(1'b0, a, s, 32'h0, 1'b0, 1, ok, bad, q, cyc);
    endtask : probe

    task automatic report_and_stop;
        if (fails == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : report_and_stop

    // Hang guard
    initial begin
        repeat (3000) @(posedge clk);
        fails++;
        $display("unexpected at %0t: run did not finish", $time);
        report_and_stop();
    end

    initial begin
        fails = 0;
        n_checks = 0;
        srst = 1'b1;
        isram_en = 1'b1;
        cache_en = 1'b0;
        parity_en = 1'b0;
        ret_isram = 1'b0;
        ret_dsram = 1'b0;
        hib_wake = 1'b0;
        repeat (3) @(posedge clk);
        #1 srst = 1'b0;
        // Retention sizes for every option pair
        for (int i = 0; i < 4; i++) begin
            {ret_isram, ret_dsram} = 2'(i);
            #1 chk32({26'h0, ret_kb}, 32'h8 + (i[1] ? 32'h10 : 32'h0)
                     + (i[0] ? 32'h8 : 32'h0), "ret_kb");
        end
        chk32({25'h0, dsram_kb}, 32'h20, "dsram_kb");
        // Lanes: word, byte and half writes, then reads of each size
        core_ok(1'b1, 32'h2000_0010, 2'h2, 32'h1234_5678, 32'h0);
        core_ok(1'b1, 32'h2000_0011, 2'h0, 32'h0000_00ab, 32'h0);
        core_ok(1'b1, 32'h2000_0012, 2'h1, 32'h0000_beef, 32'h0);
        core_ok(1'b0, 32'h2000_0010, 2'h2, 32'h0, 32'hbeef_ab78);
        core_ok(1'b0, 32'h2000_0011, 2'h0, 32'h0, 32'h0000_00ab);
        core_ok(1'b0, 32'h2000_0012, 2'h1, 32'h0, 32'h0000_beef);
        dma_ok(1'b1, 32'h2000_0020, 32'hcafe_f00d, 32'h0, n);
        core_ok(1'b0, 32'h2000_0020, 2'h2, 32'h0, 32'hcafe_f00d);
        // Both masters in one cycle: the DMA waits one cycle
        fork
            core_ok(1'b0, 32'h2000_0010, 2'h2, 32'h0, 32'hbeef_ab78);
            dma_ok(1'b0, 32'h2000_0020, 32'h0, 32'hcafe_f00d, n);
        join
        chk32(32'(n), 32'h2, "dma wait");
        // Region decode of each probe address
        for (int i = 0; i < 5; i++) begin
            probe(1'b0, pa[i], 2'h2);
            chk32({29'h0, code_sel, mmr_sel, sys_sel}, {29'h0, ps[i]},
                  "select");
            chk32(fwd_addr, pa[i], "forward address");
        end
        probe(1'b1, 32'he000_0100, 2'h2);
        chk1(bad, 1'b1, "dma private");
        probe(1'b0, 32'h2000_0000, 2'h3);
        chk1(bad, 1'b1, "bad size");
        // Instruction bank, then the same bank as data
        core_ok(1'b1, 32'h2001_0000, 2'h2, 32'h5a5a_0001, 32'h0);
        core_ok(1'b0, 32'h2001_0000, 2'h2, 32'h0, 32'h5a5a_0001);
        core_ok(1'b1, 32'h2001_7000, 2'h2, 32'h600d_0002, 32'h0);
        core_ok(1'b0, 32'h2001_7000, 2'h2, 32'h0, 32'h600d_0002);
        isram_en = 1'b0;
        #1 chk32({25'h0, dsram_kb}, 32'h40, "dsram_kb");
        core_ok(1'b1, 32'h2000_8004, 2'h2, 32'h0bad_cafe, 32'h0);
        core_ok(1'b0, 32'h2000_8004, 2'h2, 32'h0, 32'h0bad_cafe);
        // Exclusive pair to one address
        core_m.xfer(1'b0, 32'h2000_0040, 2'h2, 32'h0, 1'b1, 1, ok, bad, q, cyc);
        core_m.xfer(1'b1, 32'h2000_0040, 2'h2, 32'h77, 1'b1, 1, ok, bad, q,
                    cyc);
        chk1(core_excl_ok, 1'b1, "excl store");
        // The reservation is spent: a second store must fail and not land
        core_m.xfer(1'b1, 32'h2000_0040, 2'h2, 32'h99, 1'b1, 1, ok, bad, q,
                    cyc);
        chk1(core_excl_ok, 1'b0, "excl lost");
        core_ok(1'b0, 32'h2000_0040, 2'h2, 32'h0, 32'h0000_0077);
        // Clean word with parity on leaves the error flag low
        parity_en = 1'b1;
        core_ok(1'b1, 32'h2000_0050, 2'h2, 32'h8001_7ffe, 32'h0);
        core_ok(1'b0, 32'h2000_0050, 2'h2, 32'h0, 32'h8001_7ffe);
        @(posedge clk);
        #1 chk1(parity_err, 1'b0, "parity clean");
        // Rewritten with parity off, the stale check bits trip the flag
        parity_en = 1'b0;
        core_ok(1'b1, 32'h2000_0050, 2'h2, 32'h0000_0001, 32'h0);
        parity_en = 1'b1;
        core_ok(1'b0, 32'h2000_0050, 2'h2, 32'h0, 32'h0000_0001);
        @(posedge clk);
        #1 chk1(parity_err, 1'b1, "parity error");
        parity_en = 1'b0;
        // Cache on: lower instruction bank still served, wake invalidates
        isram_en = 1'b1;
        cache_en = 1'b1;
        core_ok(1'b0, 32'h2001_0000, 2'h2, 32'h0, 32'h5a5a_0001);
        probe(1'b0, 32'h2001_7000, 2'h2);
        chk32(q, 32'h0, "cache hides word");
        @(posedge clk);
        #1 hib_wake = 1'b1;
        @(posedge clk);
        #1 hib_wake = 1'b0;
        chk1(cache_inval, 1'b1, "cache inval");
        chk1(parity_err, 1'b1, "parity sticky");
        // Mid-run reset is the only way to clear the sticky flag
        srst = 1'b1;
        @(posedge clk);
        #1 srst = 1'b0;
        chk1(parity_err, 1'b0, "reset clears parity");
        report_and_stop();
    end
endmodule : memory_region_sram_config_test

// file: bench/mrsc_master.sv
// Bus master model standing in for the core or the DMA
`timescale 1ns/1ps
module mrsc_master (
    // Clock
    input  wire logic        clk,
    // Request
    output logic             req,
    output logic             we,
    output logic [31:0]      addr,
    output logic [1:0]       size,
    output logic [31:0]      wdata,
    output logic             excl,
    // Answer
    input  wire logic        ack,
    input  wire logic        err,
    input  wire logic [31:0] rdata
);
    // Idle until the first request
    initial begin
        req = 1'b0;
        we = 1'b0;
        addr = 32'h0;
        size = 2'h0;
        wdata = 32'h0;
        excl = 1'b0;
    end

    // Request raised after an edge, held until answered or tries run out
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [1:0] s, input logic [31:0] d,
                        input logic x, input int tries,
                        output logic ok, output logic bad,
                        output logic [31:0] q, output int cyc);
        ok = 1'b0;
        bad = 1'b0;
        q = 32'h0;
        cyc = 0;
        @(posedge clk);
        #1;
        req = 1'b1;
        we = w;
        addr = a;
        size = s;
        wdata = d;
        excl = x;
        while (!ok && !bad && cyc < tries) begin
            @(posedge clk);
            #1;
            cyc++;
            ok = (ack === 1'b1);
            bad = (err === 1'b1);
            q = rdata;
        end
        // Released address and write-data lines are inverted, so a stale value cannot pass for data
        req = 1'b0;
        addr = ~a;
        wdata = ~d;
        excl = 1'b0;
    endtask : xfer
endmodule : mrsc_master

// file: hdl/mrsc_consts.svh
// Address map, sizes and configuration constants for the memory region block
`ifndef MRSC_CONSTS_SVH
`define MRSC_CONSTS_SVH
`define MRSC_CODE_BASE    32'h0000_0000
`define MRSC_CODE_LAST    32'h0003_ffff
`define MRSC_SRAM_BASE    32'h2000_0000
`define MRSC_SRAM_LAST    32'h2004_7fff
`define MRSC_SYS_BASE     32'he000_0000
`define MRSC_SYS_LAST     32'hf7ff_ffff
`define MRSC_PPB_END      32'he004_0000
`define MRSC_BANK_BYTES   32'h0000_8000
`define MRSC_DATA_WORDS   8192
`define MRSC_ISRAM_OFF    32'h0001_0000
`define MRSC_CACHE_BYTES  32'h0000_1000
`define MRSC_RET_STEP     32'h0000_2000
`define MRSC_RET_ISRAM    32'h0000_4000
`define MRSC_PAR_BITS     2
`endif

// file: hdl/mrsc_pkg.sv
// Types shared by the memory region block
package mrsc_pkg;
    typedef enum logic [2:0] {
        MRSC_TGT_NONE,
        MRSC_TGT_CODE,
        MRSC_TGT_SRAM,
        MRSC_TGT_MMR,
        MRSC_TGT_SYS
    } mrsc_tgt_type;
    typedef enum logic [1:0] {
        MRSC_SZ_BYTE,
        MRSC_SZ_HALF,
        MRSC_SZ_WORD,
        MRSC_SZ_BAD
    } mrsc_size_type;
endpackage : mrsc_pkg

// file: hdl/mrsc_region.sv
// Region decoder and SRAM configuration for the processor memory map
`timescale 1ns/1ps
`include "mrsc_consts.svh"
module mrsc_region import mrsc_pkg::*; (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // Core master
    input  wire logic        core_req,
    input  wire logic        core_we,
    input  wire logic [31:0] core_addr,
    input  wire logic [1:0]  core_size,
    input  wire logic [31:0] core_wdata,
    input  wire logic        core_excl,
    // DMA master
    input  wire logic        dma_req,
    input  wire logic        dma_we,
    input  wire logic [31:0] dma_addr,
    input  wire logic [1:0]  dma_size,
    input  wire logic [31:0] dma_wdata,
    // Configuration
    input  wire logic        isram_en,
    input  wire logic        cache_en,
    input  wire logic        parity_en,
    input  wire logic        ret_isram,
    input  wire logic        ret_dsram,
    input  wire logic        hib_wake,
    // Answers
    output logic             core_ack,
    output logic             core_err,
    output logic [31:0]      core_rdata,
    output logic             core_excl_ok,
    output logic             dma_ack,
    output logic             dma_err,
    output logic [31:0]      dma_rdata,
    // Downstream selects
    output logic             code_sel,
    output logic             mmr_sel,
    output logic             sys_sel,
    output logic [31:0]      fwd_addr,
    // Status
    output logic             parity_err,
    output logic             cache_inval,
    output logic [5:0]       ret_kb,
    output logic [6:0]       dsram_kb
);
    typedef struct packed {
        logic        core_ack;
        logic        core_err;
        logic        core_excl_ok;
        logic        dma_ack;
        logic        dma_err;
        logic        code_sel;
        logic        mmr_sel;
        logic        sys_sel;
        logic [31:0] fwd_addr;
        logic        rd_core;
        logic        rd_dma;
        logic [1:0]  rd_lane;
        logic [1:0]  rd_size;
        logic        res_valid;
        logic [29:0] res_addr;
        logic        parity_err;
        logic        cache_inval;
    } mrsc_state_type;

    mrsc_state_type state;
    mrsc_state_type next_state;
    mrsc_sram_if    sram ();

    // Core wins when both masters hit SRAM; DMA retries next cycle
    logic        sel_dma;
    logic [31:0] a;
    logic        we;
    logic [1:0]  sz;
    logic [31:0] wd;
    logic        in_code, in_sram, in_dsram, in_isram, in_sys, in_ppb;
    logic [31:0] off;
    logic [31:0] dlimit;
    logic        sram_hit;
    logic [3:0]  be;
    logic        d_in_sram, d_in_ppb, d_in_sys, d_in_code, d_ok;
    logic [31:0] iw_off;
    logic [31:0] rd_mask;

    function automatic logic [3:0] mrsc_lanes(input logic [1:0] s,
                                             input logic [1:0] lo);
        case (s)
            MRSC_SZ_BYTE: mrsc_lanes = 4'h1 << lo;
            MRSC_SZ_HALF: mrsc_lanes = lo[1] ? 4'hc : 4'h3;
            default:      mrsc_lanes = 4'hf;
        endcase
    endfunction : mrsc_lanes

    // Data SRAM size grows when instruction SRAM is off
    assign dlimit = isram_en ? `MRSC_BANK_BYTES
                             : (`MRSC_BANK_BYTES << 1);
    assign dsram_kb = isram_en ? 7'h20 : 7'h40;
    // Retained amount: base 8 kB plus optional banks
    assign ret_kb = 6'h08 + (ret_isram ? 6'h10 : 6'h00)
                  + (ret_dsram ? 6'h08 : 6'h00);

    // DMA region decode
    assign d_in_code = dma_addr <= `MRSC_CODE_LAST;
    assign d_in_sram = dma_addr >= `MRSC_SRAM_BASE
                    && dma_addr <= `MRSC_SRAM_LAST;
    assign d_in_sys  = dma_addr >= `MRSC_SYS_BASE
                    && dma_addr <= `MRSC_SYS_LAST;
    assign d_in_ppb  = d_in_sys && dma_addr < `MRSC_PPB_END;
    assign d_ok = d_in_code || d_in_sram;

    always_comb begin
        sel_dma = !core_req && dma_req && d_in_sram;
        a  = sel_dma ? dma_addr  : core_addr;
        we = sel_dma ? dma_we    : core_we;
        sz = sel_dma ? dma_size  : core_size;
        wd = sel_dma ? dma_wdata : core_wdata;
        in_code = core_addr <= `MRSC_CODE_LAST;
        in_sram = a >= `MRSC_SRAM_BASE && a <= `MRSC_SRAM_LAST;
        in_sys  = core_addr >= `MRSC_SYS_BASE
               && core_addr <= `MRSC_SYS_LAST;
        in_ppb  = in_sys && core_addr < `MRSC_PPB_END;
        off = a - `MRSC_SRAM_BASE;
        in_dsram = in_sram && off < dlimit;
        // Instruction bank sits above data; cache steals its top 4 kB
        iw_off = off - `MRSC_ISRAM_OFF;
        in_isram = in_sram && isram_en && off >= `MRSC_ISRAM_OFF
                && iw_off < (`MRSC_BANK_BYTES - (cache_en ?
                   `MRSC_CACHE_BYTES : 32'h0000_0000));
        sram_hit = (in_dsram || in_isram) && (sz != MRSC_SZ_BAD);
        be = mrsc_lanes(sz, a[1:0]);
        sram.en    = (sel_dma || core_req) && sram_hit;
        sram.we    = we;
        // Data words fill the low half, or the whole array with the bank off
        sram.idx   = in_isram ? {1'b1, iw_off[14:2]}
                              : off[15:2];
        sram.be    = be;
        sram.wdata = wd << {a[1:0], 3'b000};
        sram.par_en = parity_en;
        // Exclusive store loses if reservation is gone
        if (!sel_dma && core_req && core_excl && core_we
            && !(state.res_valid && state.res_addr == core_addr[31:2]))
            sram.en = 1'b0;

        next_state = state;
        next_state.core_ack = core_req;
        next_state.core_err = core_req && !(in_code || sram_hit
                              || (in_sram && !in_dsram && !in_isram)
                              || in_sys) && !(in_sram && sram_hit);
        next_state.dma_ack = dma_req && (!d_in_sram || sel_dma);
        next_state.dma_err = dma_req && (d_in_ppb || !d_ok);
        next_state.code_sel = core_req && in_code;
        next_state.mmr_sel = core_req && in_sram && !in_dsram && !in_isram
                          && off >= (`MRSC_BANK_BYTES << 1);
        next_state.sys_sel = core_req && in_sys;
        next_state.fwd_addr = core_addr;
        next_state.rd_core = core_req && !sel_dma && sram.en && !we;
        next_state.rd_dma = sel_dma && sram.en && !we;
        next_state.rd_lane = a[1:0];
        next_state.rd_size = sz;
        next_state.core_excl_ok = 1'b0;
        // Reservation monitor: any other write to the word clears it
        if (sram.en && we && state.res_addr == a[31:2])
            next_state.res_valid = 1'b0;
        if (core_req && core_excl && !core_we && sram_hit) begin
            next_state.res_valid = 1'b1;
            next_state.res_addr = core_addr[31:2];
        end else if (core_req && core_excl && core_we) begin
            next_state.core_excl_ok = sram.en;
            next_state.res_valid = 1'b0;
        end
        // Sticky parity flag; a new read never clears it, only reset does
        next_state.parity_err = state.parity_err || sram.par_err;
        // Cache contents lost across hibernate
        next_state.cache_inval = hib_wake || (state.cache_inval && !cache_en);
        if (hib_wake)
            next_state.cache_inval = 1'b1;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    mrsc_sram #(.WORDS(16384)) u_sram (
        .clk  (clk),
        .srst (srst),
        .port (sram.mem)
    );

    // Narrow reads return only their own lanes, upper bits zero
    assign rd_mask = (state.rd_size == MRSC_SZ_BYTE) ? 32'h0000_00ff
                   : (state.rd_size == MRSC_SZ_HALF) ? 32'h0000_ffff
                   : 32'hffff_ffff;

    // Read data aligned back to the low bits
    assign core_rdata   = state.rd_core
        ? (sram.rdata >> {state.rd_lane, 3'b000}) & rd_mask
        : 32'h0000_0000;
    assign dma_rdata    = state.rd_dma
        ? (sram.rdata >> {state.rd_lane, 3'b000}) & rd_mask
        : 32'h0000_0000;
    assign core_ack     = state.core_ack;
    assign core_err     = state.core_err;
    assign core_excl_ok = state.core_excl_ok;
    assign dma_ack      = state.dma_ack;
    assign dma_err      = state.dma_err;
    assign code_sel     = state.code_sel;
    assign mmr_sel      = state.mmr_sel;
    assign sys_sel      = state.sys_sel;
    assign fwd_addr     = state.fwd_addr;
    assign parity_err   = state.parity_err;
    assign cache_inval  = state.cache_inval;

    // Master access and refusal
    a_dma_ppb_refused: assert property (
        @(posedge clk) disable iff (srst)
        dma_req && d_in_ppb |=> dma_err)
        else $error("DMA access to private space not refused");
    a_core_no_wait: assert property (
        @(posedge clk) disable iff (srst)
        core_req |=> core_ack)
        else $error("Core access took a wait state");
    a_dma_yields: assert property (
        @(posedge clk) disable iff (srst)
        core_req && dma_req && d_in_sram |=> !dma_ack)
        else $error("DMA served while core held the SRAM");
    a_dma_sram_served: assert property (
        @(posedge clk) disable iff (srst)
        !core_req && dma_req && d_in_sram |=> dma_ack && !dma_err)
        else $error("Free DMA access to SRAM not served");

    // Region routing
    a_code_route: assert property (
        @(posedge clk) disable iff (srst)
        core_req && core_addr <= `MRSC_CODE_LAST |=> code_sel)
        else $error("Code access not routed");
    a_sys_route: assert property (
        @(posedge clk) disable iff (srst)
        core_req && in_sys |=> sys_sel && !code_sel)
        else $error("System access not routed");
    a_sram_no_wait: assert property (
        @(posedge clk) disable iff (srst)
        core_req && in_dsram && core_size != 2'h3 |=> core_ack && !core_err)
        else $error("Data SRAM access not served");
    a_size_refused: assert property (
        @(posedge clk) disable iff (srst)
        core_req && core_size == MRSC_SZ_BAD && in_dsram |=> core_err)
        else $error("Illegal access size not refused");
    a_cache_hidden: assert property (
        @(posedge clk) disable iff (srst)
        core_req && isram_en && cache_en && in_sram
        && off >= `MRSC_ISRAM_OFF + `MRSC_BANK_BYTES - `MRSC_CACHE_BYTES
        && off < `MRSC_ISRAM_OFF + `MRSC_BANK_BYTES |-> !sram.en)
        else $error("Cache space reached as instruction SRAM");

    // Exclusive monitor
    a_excl_lost: assert property (
        @(posedge clk) disable iff (srst)
        core_req && core_excl && core_we
        && !(state.res_valid && state.res_addr == core_addr[31:2])
        |=> !core_excl_ok)
        else $error("Exclusive store passed without reservation");
    a_excl_kept: assert property (
        @(posedge clk) disable iff (srst)
        core_req && core_excl && core_we && sram_hit && state.res_valid
        && state.res_addr == core_addr[31:2] |=> core_excl_ok)
        else $error("Exclusive store failed with reservation");

    // Sizes and retention
    a_ret_base: assert property (
        @(posedge clk) disable iff (srst)
        ret_kb >= 6'h08 && ret_kb <= 6'h20)
        else $error("Retention outside range");
    a_ret_step: assert property (
        @(posedge clk) disable iff (srst)
        ret_kb[2:0] == 3'h0)
        else $error("Retention not in 8 kB steps");
    a_dsram_size: assert property (
        @(posedge clk) disable iff (srst)
        !isram_en |-> dsram_kb == 7'h40)
        else $error("Data SRAM not doubled");
    a_dsram_base: assert property (
        @(posedge clk) disable iff (srst)
        isram_en |-> dsram_kb == 7'h20)
        else $error("Data SRAM not one bank");

    // Parity flag and cache invalidation
    a_par_flag: assert property (
        @(posedge clk) disable iff (srst)
        sram.par_err |=> parity_err)
        else $error("Parity mismatch not flagged");
    a_par_sticky: assert property (
        @(posedge clk) disable iff (srst)
        $rose(parity_err) |=> parity_err [*2])
        else $error("Parity flag dropped");
    a_wake_inval: assert property (
        @(posedge clk) disable iff (srst)
        hib_wake |=> cache_inval)
        else $error("Cache not invalid after wake");
endmodule : mrsc_region

// file: hdl/mrsc_sram.sv
// SRAM word array with per-word two-bit parity
`timescale 1ns/1ps
`include "mrsc_consts.svh"
module mrsc_sram import mrsc_pkg::*; #(
    parameter int WORDS = 16384
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Array port
    mrsc_sram_if.mem  port
);
    typedef struct packed {
        logic [31:0] rdata;
        logic        par_err;
    } mrsc_mem_state_type;

    mrsc_mem_state_type state;
    mrsc_mem_state_type next_state;
    logic [31:0] mem [WORDS];
    logic [`MRSC_PAR_BITS-1:0] par [WORDS];
    logic [`MRSC_PAR_BITS-1:0] wpar;
    logic [31:0] merged;

    // Parity over each half-word
    function automatic logic [1:0] mrsc_parity(input logic [31:0] w);
        mrsc_parity = {^w[31:16], ^w[15:0]};
    endfunction : mrsc_parity

    // Byte lanes merge into the stored word
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            merged[b*8 +: 8] = port.be[b] ? port.wdata[b*8 +: 8]
                                          : mem[port.idx][b*8 +: 8];
        end
        wpar = mrsc_parity(merged);
    end

    // Read data and parity check
    always_comb begin
        next_state = state;
        next_state.par_err = 1'b0;
        if (port.en && !port.we) begin
            next_state.rdata = mem[port.idx];
            next_state.par_err = port.par_en &&
                (par[port.idx] != mrsc_parity(mem[port.idx]));
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Storage, no reset: contents are software data
    always_ff @(posedge clk) begin
        if (port.en && port.we) begin
            mem[port.idx] <= merged;
            // Check bits follow only while parity is on; words written
            // with it off must be rewritten before turning it on
            if (port.par_en)
                par[port.idx] <= wpar;
        end
    end

    assign port.rdata   = state.rdata;
    assign port.par_err = state.par_err;
endmodule : mrsc_sram

// file: hdl/mrsc_sram_if.sv
// Word-level port between the region decoder and the SRAM array
`timescale 1ns/1ps
interface mrsc_sram_if;
    logic        en;
    logic        we;
    logic [13:0] idx;
    logic [3:0]  be;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        par_err;
    logic        par_en;
    modport ctrl (output en, we, idx, be, wdata, par_en,
                  input rdata, par_err);
    modport mem  (input en, we, idx, be, wdata, par_en,
                  output rdata, par_err);
endinterface : mrsc_sram_if
